// [core/kpev_pkg.sv]
// Constants, register map and carrier types for the keypad event unit.
// Assumes a classic Wishbone slave with 32-bit data; registers E9 to EC sit one byte apart, F0 to F8 one word apart.
package kpev_pkg;
   // ----------------------------------------
   // Register byte addresses
   // ----------------------------------------
   localparam logic [7:0] KPEV_ADDR_ENABLE = 8'h00_E9;
   localparam logic [7:0] KPEV_ADDR_FLAGS = 8'h00_EA;
   localparam logic [7:0] KPEV_ADDR_SEL_LOW = 8'h00_EB;
   localparam logic [7:0] KPEV_ADDR_SEL_HIGH = 8'h00_EC;
   localparam logic [7:0] KPEV_ADDR_IRQ_CTRL = 8'h00_F0;
   localparam logic [7:0] KPEV_ADDR_IRQ_STAT = 8'h00_F4;
   localparam logic [7:0] KPEV_ADDR_IRQ_MASK = 8'h00_F8;

   // ----------------------------------------
   // Reset values and widths
   // ----------------------------------------
   localparam int KPEV_CHANNELS = 8;
   localparam logic [7:0] KPEV_RST_BYTE = 8'h00_00;
   localparam logic [1:0] KPEV_RST_EVT = 2'h0;
   localparam logic KPEV_RST_GIE = 1'b0;
   // Machine cycle of the core, in clocks; flag delay in machine cycles
   localparam int KPEV_MACHINE_CLKS = 4;
   localparam int KPEV_FLAG_DELAY_MC = 2;
   localparam int KPEV_FLAG_DELAY_CLKS = KPEV_MACHINE_CLKS * KPEV_FLAG_DELAY_MC;

   // Trigger encodings {high,low}
   localparam logic [1:0] KPEV_TRIG_FALL = 2'h0;
   localparam logic [1:0] KPEV_TRIG_RISE = 2'h1;
   localparam logic [1:0] KPEV_TRIG_BOTH = 2'h2;
   localparam logic [1:0] KPEV_TRIG_LOW = 2'h3;

   // Event status bits
   localparam int KPEV_EVT_FLAG = 0;
   localparam int KPEV_EVT_WAKE = 1;

   typedef struct packed {
      logic [7:0] enable;
      logic [7:0] sel_low;
      logic [7:0] sel_high;
      logic gie;
   } kpev_cfg_type;

   typedef struct packed {
      logic [7:0] adr;
      logic we;
      logic [3:0] sel;
      logic [31:0] dat;
   } kpev_wbreq_type;
endpackage

// [core/kpev_unit.sv]
// Keypad event unit: per-pin trigger detection, flags and interrupt.
// Assumes a classic Wishbone master on mclk and asynchronous key pins.
//
// Chosen here: the Wishbone register port.
`timescale 1ns/10ps
module kpev_unit (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [7:0] key_pins,
   input wire logic cpu_sleeping,
   output logic keypad_irq,
   output logic event_irq,
   output logic cpu_wake
);
   import kpev_pkg::*;

   // ----------------------------------------
   // Pin synchronisers and edge history
   // ----------------------------------------
   logic [7:0] sync1_q, sync1_d, sync2_q, sync2_d, prev_q, prev_d;

   always_comb begin
      sync1_d = key_pins;
      sync2_d = sync1_q;
      prev_d = sync2_q;
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sync1_q <= 8'hFF;
         sync2_q <= 8'hFF;
         prev_q <= 8'hFF;
      end else if (clk_en) begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         prev_q <= prev_d;
      end
   end

   // ----------------------------------------
   // Registers and bus slave
   // ----------------------------------------
   kpev_cfg_type cfg_q, cfg_d;
   kpev_wbreq_type req;
   logic [7:0] flags_q, flags_d;
   logic [1:0] evt_q, evt_d, mask_q, mask_d;
   logic ack_q, ack_d;
   logic [31:0] rdat_q, rdat_d;
   logic irq_q, irq_d, eirq_q, eirq_d, wake_q, wake_d;
   logic [7:0] trig;
   logic [7:0] pend_q [KPEV_FLAG_DELAY_CLKS];
   logic [7:0] pend_d [KPEV_FLAG_DELAY_CLKS];
   logic wr, rd_go;

   assign req = '{adr: wb_adr_i, we: wb_we_i, sel: wb_sel_i, dat: wb_dat_i};
   assign wr = wb_cyc_i && wb_stb_i && !ack_q && req.we && req.sel[0];
   assign rd_go = wb_cyc_i && wb_stb_i && !ack_q;

   // Trigger per channel
   genvar g;
   generate
      for (g = 0; g < KPEV_CHANNELS; g++) begin : g_trig
         always_comb begin
            unique case ({cfg_q.sel_high[g], cfg_q.sel_low[g]})
               KPEV_TRIG_FALL: trig[g] = prev_q[g] && !sync2_q[g];
               KPEV_TRIG_RISE: trig[g] = !prev_q[g] && sync2_q[g];
               KPEV_TRIG_BOTH: trig[g] = prev_q[g] != sync2_q[g];
               KPEV_TRIG_LOW: trig[g] = !sync2_q[g];
            endcase
         end
      end
   endgenerate

   always_comb begin
      logic [7:0] lvl;
      logic [7:0] newf;
      lvl = cfg_q.sel_high & cfg_q.sel_low;
      newf = pend_q[KPEV_FLAG_DELAY_CLKS-1];
      cfg_d = cfg_q;
      mask_d = mask_q;
      // Delay line: a trigger ripens after two machine cycles
      pend_d[0] = trig & cfg_q.enable & ~lvl;
      for (int i = 1; i < KPEV_FLAG_DELAY_CLKS; i++) begin
         pend_d[i] = pend_q[i-1];
      end
      flags_d = flags_q;
      evt_d = evt_q;
      if (wr) begin
         unique case (req.adr)
            KPEV_ADDR_ENABLE: cfg_d.enable = req.dat[7:0];
            KPEV_ADDR_SEL_LOW: cfg_d.sel_low = req.dat[7:0];
            KPEV_ADDR_SEL_HIGH: cfg_d.sel_high = req.dat[7:0];
            KPEV_ADDR_IRQ_CTRL: cfg_d.gie = req.dat[0];
            KPEV_ADDR_FLAGS: flags_d = flags_q & req.dat[7:0];
            KPEV_ADDR_IRQ_STAT: evt_d = evt_q & ~req.dat[1:0];
            KPEV_ADDR_IRQ_MASK: mask_d = req.dat[1:0];
            default: ;
         endcase
      end
      // Set wins over a clear in the same cycle
      flags_d = flags_d | newf;
      // Level channels follow the inverted pin, writes ignored
      flags_d = (flags_d & ~lvl) | (lvl & cfg_q.enable & ~sync2_q);
      if (|newf) begin
         evt_d[KPEV_EVT_FLAG] = 1'b1;
      end
      irq_d = cfg_q.gie && |flags_q;
      // Wake ignores the global enable so a sleeping core can resume
      wake_d = cpu_sleeping && |flags_q;
      if (wake_d && !wake_q) begin
         evt_d[KPEV_EVT_WAKE] = 1'b1;
      end
      eirq_d = |(evt_q & mask_q);
      ack_d = rd_go;
      rdat_d = '0;
      unique case (req.adr)
         KPEV_ADDR_ENABLE: rdat_d[7:0] = cfg_q.enable;
         KPEV_ADDR_FLAGS: rdat_d[7:0] = flags_q;
         KPEV_ADDR_SEL_LOW: rdat_d[7:0] = cfg_q.sel_low;
         KPEV_ADDR_SEL_HIGH: rdat_d[7:0] = cfg_q.sel_high;
         KPEV_ADDR_IRQ_CTRL: rdat_d[0] = cfg_q.gie;
         KPEV_ADDR_IRQ_STAT: rdat_d[1:0] = evt_q;
         KPEV_ADDR_IRQ_MASK: rdat_d[1:0] = mask_q;
         default: rdat_d = '0;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cfg_q <= '{enable: KPEV_RST_BYTE, sel_low: KPEV_RST_BYTE,
                    sel_high: KPEV_RST_BYTE, gie: KPEV_RST_GIE};
         flags_q <= KPEV_RST_BYTE;
         evt_q <= KPEV_RST_EVT;
         mask_q <= KPEV_RST_EVT;
         ack_q <= 1'b0;
         rdat_q <= '0;
         irq_q <= 1'b0;
         eirq_q <= 1'b0;
         wake_q <= 1'b0;
         for (int i = 0; i < KPEV_FLAG_DELAY_CLKS; i++) begin
            pend_q[i] <= KPEV_RST_BYTE;
         end
      end else if (clk_en) begin
         cfg_q <= cfg_d;
         flags_q <= flags_d;
         evt_q <= evt_d;
         mask_q <= mask_d;
         ack_q <= ack_d;
         rdat_q <= rdat_d;
         irq_q <= irq_d;
         eirq_q <= eirq_d;
         wake_q <= wake_d;
         for (int i = 0; i < KPEV_FLAG_DELAY_CLKS; i++) begin
            pend_q[i] <= pend_d[i];
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign keypad_irq = irq_q;
   assign event_irq = eirq_q;
   assign cpu_wake = wake_q;
endmodule

// [verif/kpev_monitor.sv]
// Port checker for the keypad event unit.
// Assumes clk_en held high; bound onto kpev_unit.
`timescale 1ns/10ps
module kpev_monitor (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic cpu_sleeping,
   input wire logic keypad_irq,
   input wire logic event_irq,
   input wire logic cpu_wake
);
   // ----------------
   // Properties
   // ----------------
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   a_ack_answer: assert property (s_req |=> wb_ack_o) else $error("ack missing");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
   a_read_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h00_0000)
      else $error("upper bits set");
   a_unmapped_zero: assert property (s_req ##0 (!wb_we_i && wb_adr_i == 8'h00_E8)
      |=> wb_dat_o == 32'h0000_0000) else $error("unmapped read");
   a_reset_quiet: assert property ($rose(rst_n) |-> !(keypad_irq || event_irq || cpu_wake))
      else $error("output after reset");
   a_wake_asleep: assert property (!cpu_sleeping |=> !cpu_wake) else $error("wake awake");
   a_irq_wake: assert property (keypad_irq && $past(cpu_sleeping) |-> cpu_wake)
      else $error("irq without wake");
endmodule
bind kpev_unit kpev_monitor i_mon (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .cpu_sleeping(cpu_sleeping), .keypad_irq(keypad_irq),
   .event_irq(event_irq), .cpu_wake(cpu_wake));

// [verif/kpev_keys.sv]
// Key switch model on the port pins.
// Assumes pull-ups: a released key reads high.
`timescale 1ns/10ps
module kpev_keys (
   input wire logic mclk,
   input wire logic [7:0] press,
   output logic [7:0] key_pins = 8'hFF
);
   // Contact to ground; no bounce, so edges are clean
   always @(posedge mclk) begin
      key_pins <= ~press;
   end
endmodule

// [verif/tb_top.sv]
// Bench for the keypad event unit over Wishbone.
// Assumes kpev_pkg, kpev_unit and kpev_keys compiled first.
`timescale 1ns/10ps
module tb_top;
   import kpev_pkg::*;
   logic mclk = 1'b0, rst_n = 1'b0, cyc = 1'b0, we = 1'b0, slp = 1'b0;
   logic [7:0] adr = 8'h00_00, press = 8'h00_00, kp, rv;
   logic [31:0] wdat = 32'h0000_0000, rdat;
   logic ack, kirq, eirq, wake;
   logic [7:0] ra [8] = '{8'h00_E9, 8'h00_EA, 8'h00_EB, 8'h00_EC, 8'h00_F0, 8'h00_F4, 8'h00_F8, 8'h00_E8};
   int n_fail = 0, checks = 0;
   always #12.5 mclk = ~mclk;
   kpev_keys i_keys (.mclk(mclk), .press(press), .key_pins(kp));
   kpev_unit i_dut (.mclk(mclk), .rst_n(rst_n), .clk_en(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .key_pins(kp), .cpu_sleeping(slp), .keypad_irq(kirq),
      .event_irq(eirq), .cpu_wake(wake));
   // ----------------
   // Tasks
   // ----------------
   task automatic test_done();
      $display("Counts: %0d checks, %0d failures", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h00_0000, d};
      for (int i = 0; i < 20 && ack !== 1'b1; i++) begin
         @(posedge mclk);
      end
      if (ack !== 1'b1) begin
         n_fail++;
         test_done();
      end
      rv = rdat[7:0];
      cyc <= 1'b0;
      @(posedge mclk);
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      bus(1'b1, 8'h00_E8, 8'hFF);
      foreach (ra[i]) begin
         bus(1'b0, ra[i], 8'h00_00);
         chk(rv, KPEV_RST_BYTE);
      end
      $display("test reset done");
      // Ch0 fall, ch1 rise, ch2 both, ch3 level; ch4 left disabled
      bus(1'b1, 8'h00_E9, 8'h0F);
      bus(1'b1, 8'h00_EB, 8'h0A);
      bus(1'b1, 8'h00_EC, 8'h0C);
      bus(1'b1, 8'h00_F0, 8'h01);
      bus(1'b1, 8'h00_F8, 8'h01);
      bus(1'b0, 8'h00_EA, 8'h00);
      chk(rv, 8'h00);
      press <= 8'h1F;
      repeat (9) @(posedge mclk);
      // Level channel already drives the irq here; edge timing shows on the event status
      chk(eirq, 1'b0);
      repeat (7) @(posedge mclk);
      chk(kirq, 1'b1);
      chk(eirq, 1'b1);
      bus(1'b0, 8'h00_EA, 8'h00);
      chk(rv, 8'h0D);
      press <= 8'h00;
      repeat (16) @(posedge mclk);
      bus(1'b0, 8'h00_EA, 8'h00);
      chk(rv, 8'h07);
      bus(1'b1, 8'h00_F8, 8'h00);
      chk(eirq, 1'b0);
      bus(1'b1, 8'h00_EA, 8'h00);
      bus(1'b0, 8'h00_EA, 8'h00);
      chk(rv, 8'h00);
      bus(1'b1, 8'h00_F4, 8'h03);
      bus(1'b0, 8'h00_F4, 8'h00);
      chk(rv, 8'h00);
      press <= 8'h08;
      repeat (16) @(posedge mclk);
      bus(1'b1, 8'h00_EA, 8'h00);
      bus(1'b0, 8'h00_EA, 8'h00);
      chk(rv, 8'h08);
      $display("test trigger done");
      // Gie off shows wake does not depend on it
      bus(1'b1, 8'h00_F0, 8'h00);
      slp <= 1'b1;
      press <= 8'h01;
      repeat (16) @(posedge mclk);
      chk(wake, 1'b1);
      chk(kirq, 1'b0);
      bus(1'b1, 8'h00_F0, 8'h01);
      chk(kirq, 1'b1);
      slp <= 1'b0;
      repeat (2) @(posedge mclk);
      chk(wake, 1'b0);
      $display("test wake done");
      test_done();
   end
endmodule
